//--- hw/video_scaler_filter_control.v
// video scaler filter control: double-buffered scale registers,
// horizontal interpolator on a pixel stream, vertical phase control.
// assumes one clock, synchronous inputs, pixels as {c2,c1,c0} bytes
// with c0 the luma (or red) component.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`include "video_scaler_regs.vh"
`default_nettype none

////////////////////////////////////////////////////////////////////////
// pixel fifo
module pixel_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // fill side
  input wire i_flush,
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_in_ready,
  // drain side
  output wire o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready,
  // occupancy
  output wire [AW:0] o_level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  assign o_in_ready = (count_r != DEPTH[AW:0]);
  assign o_out_valid = (count_r != {(AW+1){1'b0}});
  assign o_out_data = mem[rd_ptr_r];
  assign o_level = count_r;
  assign push = i_in_valid && o_in_ready && !i_flush;
  assign pop = o_out_valid && i_out_ready && !i_flush;

  // storage has no reset; only the pointers and count need one
  always @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else if (i_flush) begin
      // flush wins over a push or pop in the same cycle
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // pixel_fifo

////////////////////////////////////////////////////////////////////////
// How it works
// - bit 20 enables luma interpolation in yuv, all components in rgb.
// - bit 19 enables both chroma interpolators in yuv modes.
// - a cleared enable makes affected channels repeat source pixels.
// - horizontal increment bits 12:0 set the horizontal scale factor.
// - vertical increment bits 12:0 set the vertical scale factor.
// - scale register writes land in shadows; active copies load only during vsync.
// - both scale registers reset to all zeros.
module video_scaler_filter_control (
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // video timing
  input wire i_vsync,
  input wire i_hline_start,
  input wire i_vline_done,
  // source pixels
  input wire i_pix_valid,
  input wire [`PIX_WIDTH-1:0] i_pix_data,
  output wire o_pix_ready,
  // scaled pixels
  output reg o_out_valid,
  output reg [`PIX_WIDTH-1:0] o_out_data,
  input wire i_out_ready,
  // vertical filter control
  output reg [`FRAC_BITS-1:0] o_vphase,
  output reg o_vline_advance,
  output reg o_vert_luma_on,
  output reg o_vert_chroma_on
);
  localparam [2:0] ST_FILL = 3'h1;
  localparam [2:0] ST_EMIT = 3'h2;
  localparam [2:0] ST_ADV = 3'h4;

  reg [31:0] hshadow_r;
  reg [31:0] vshadow_r;
  reg [31:0] hactive_r;
  reg [31:0] vactive_r;
  reg rgb_mode_r;
  reg [2:0] state_r;
  reg [1:0] held_r;
  reg [`PIX_WIDTH-1:0] p0_r;
  reg [`PIX_WIDTH-1:0] p1_r;
  reg [`FRAC_BITS-1:0] hfrac_r;
  reg [`FRAC_BITS-1:0] vfrac_r;
  reg [31:0] rdata_nxt;

  wire fifo_valid;
  wire [`PIX_WIDTH-1:0] fifo_data;
  wire fifo_pop;
  wire [`FIFO_AW:0] fifo_level;
  wire slot_free;
  wire emit;
  wire [12:0] hinc;
  wire [12:0] vinc;
  wire [13:0] hsum;
  wire [13:0] vsum;
  wire [2:0] comp_en;
  wire [`PIX_WIDTH-1:0] interp;
  wire [31:0] status;

  ////////////////////////////////////////////////////////////////////
  // register port
  // scale register reads return the shadow copy, not the active one; status reads show the active enables
  // reserved bits
  always @* begin
    case (i_addr)
      `HSCALE_CTRL_OFF: rdata_nxt = hshadow_r & `SCALE_CTRL_MASK;
      `VSCALE_CTRL_OFF: rdata_nxt = vshadow_r & `SCALE_CTRL_MASK;
      `SCALER_MODE_OFF: rdata_nxt = {31'h0, rgb_mode_r};
      `SCALER_STAT_OFF: rdata_nxt = status;
      default: rdata_nxt = 32'h0;
    endcase
  end

  assign status = {20'h0, vactive_r[`CHROMA_EN_BIT], vactive_r[`LUMA_EN_BIT],
                   hactive_r[`CHROMA_EN_BIT], hactive_r[`LUMA_EN_BIT],
                   3'h0, !o_pix_ready, fifo_level};

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hshadow_r <= `SCALE_CTRL_RESET;
      vshadow_r <= `SCALE_CTRL_RESET;
      hactive_r <= `SCALE_CTRL_RESET;
      vactive_r <= `SCALE_CTRL_RESET;
      rgb_mode_r <= `MODE_RESET;
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= i_rd ? rdata_nxt : 32'h0;
      if (i_wr && i_addr == `HSCALE_CTRL_OFF) begin
        hshadow_r <= i_wdata & `SCALE_CTRL_MASK;
      end
      if (i_wr && i_addr == `VSCALE_CTRL_OFF) begin
        vshadow_r <= i_wdata & `SCALE_CTRL_MASK;
      end
      if (i_wr && i_addr == `SCALER_MODE_OFF) begin
        rgb_mode_r <= i_wdata[`MODE_RGB_BIT];
      end
      // a write in a vsync cycle misses that load; the active copy takes it at the next vsync
      // load at vsync
      if (i_vsync) begin
        hactive_r <= hshadow_r;
        vactive_r <= vshadow_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // channel enables
  // luma or all rgb
  assign comp_en[0] = hactive_r[`LUMA_EN_BIT];
  assign comp_en[1] = rgb_mode_r ? hactive_r[`LUMA_EN_BIT] : hactive_r[`CHROMA_EN_BIT];
  assign comp_en[2] = comp_en[1];

  ////////////////////////////////////////////////////////////////////
  // source buffer
  pixel_fifo #(
    .WIDTH(`PIX_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_flush(1'b0),
    .i_in_valid(i_pix_valid),
    .i_in_data(i_pix_data),
    .o_in_ready(o_pix_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(fifo_pop),
    .o_level(fifo_level)
  );

  ////////////////////////////////////////////////////////////////////
  // horizontal interpolator
  // a is the older source pixel, b the newer one
  // weights sum to 4096, so the blend never carries past bit 19
  // replicate when disabled
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : g_comp
      wire [7:0] a = p0_r[8*c+7:8*c];
      wire [7:0] b = p1_r[8*c+7:8*c];
      wire [20:0] wa = a * (`PHASE_ONE - {1'b0, hfrac_r});
      wire [20:0] wb = b * {1'b0, hfrac_r};
      wire [21:0] mix = {1'b0, wa} + {1'b0, wb};
      assign interp[8*c+7:8*c] = comp_en[c] ? mix[19:12] : a;
    end
  endgenerate

  assign hinc = hactive_r[`INC_MSB:`INC_LSB];
  // an increment above 4096 still steps one source pixel only
  // phase accumulate
  assign hsum = {2'b0, hfrac_r} + {1'b0, hinc};
  // line start blocks emits and pops so the restart is clean
  assign slot_free = !o_out_valid || i_out_ready;
  assign emit = (state_r == ST_EMIT) && slot_free && !i_hline_start;
  assign fifo_pop = fifo_valid && !i_hline_start
                    && (state_r == ST_FILL || state_r == ST_ADV);

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_FILL;
      held_r <= 2'h0;
      p0_r <= {`PIX_WIDTH{1'b0}};
      p1_r <= {`PIX_WIDTH{1'b0}};
      hfrac_r <= {`FRAC_BITS{1'b0}};
      o_out_valid <= 1'b0;
      o_out_data <= {`PIX_WIDTH{1'b0}};
    end else begin
      if (slot_free) begin
        o_out_valid <= 1'b0;
      end
      if (i_hline_start) begin
        state_r <= ST_FILL;
        held_r <= 2'h0;
        hfrac_r <= {`FRAC_BITS{1'b0}};
      end else begin
        case (state_r)
          ST_FILL: begin
            if (fifo_pop) begin
              p0_r <= p1_r;
              p1_r <= fifo_data;
              held_r <= held_r + 2'h1;
              if (held_r == 2'h1) begin
                state_r <= ST_EMIT;
              end
            end
          end
          ST_EMIT: begin
            if (emit) begin
              o_out_valid <= 1'b1;
              o_out_data <= interp;
              hfrac_r <= hsum[`FRAC_BITS-1:0];
              if (hsum[13:12] != 2'h0) begin
                state_r <= ST_ADV;
              end
            end
          end
          ST_ADV: begin
            // waits here until the next source pixel arrives
            if (fifo_pop) begin
              p0_r <= p1_r;
              p1_r <= fifo_data;
              state_r <= ST_EMIT;
            end
          end
          default: begin
            state_r <= ST_FILL;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // vertical phase control
  // vertical increment
  assign vinc = vactive_r[`INC_MSB:`INC_LSB];
  assign vsum = {2'b0, vfrac_r} + {1'b0, vinc};

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vfrac_r <= {`FRAC_BITS{1'b0}};
      o_vphase <= {`FRAC_BITS{1'b0}};
      o_vline_advance <= 1'b0;
      o_vert_luma_on <= 1'b0;
      o_vert_chroma_on <= 1'b0;
    end else begin
      // enables lag the active copy by one cycle
      // vertical luma
      o_vert_luma_on <= vactive_r[`LUMA_EN_BIT];
      o_vert_chroma_on <= rgb_mode_r ? vactive_r[`LUMA_EN_BIT]
                                     : vactive_r[`CHROMA_EN_BIT];
      o_vline_advance <= 1'b0;
      // vsync wins over a line done in the same cycle
      if (i_vsync) begin
        vfrac_r <= {`FRAC_BITS{1'b0}};
        o_vphase <= {`FRAC_BITS{1'b0}};
      end else if (i_vline_done) begin
        vfrac_r <= vsum[`FRAC_BITS-1:0];
        o_vphase <= vsum[`FRAC_BITS-1:0];
        o_vline_advance <= (vsum[13:12] != 2'h0);
      end
    end
  end
endmodule // video_scaler_filter_control

`default_nettype wire

//--- hw/video_scaler_regs.vh
// register map and field layout of the video scaler filter control
// assumes byte addresses on an 8-bit register port with 32-bit data
`ifndef VIDEO_SCALER_REGS_VH
`define VIDEO_SCALER_REGS_VH

// register byte offsets
`define HSCALE_CTRL_OFF 8'h20
`define VSCALE_CTRL_OFF 8'h28
`define SCALER_MODE_OFF 8'h40
`define SCALER_STAT_OFF 8'h44

// scale control fields
`define LUMA_EN_BIT 20
`define CHROMA_EN_BIT 19
`define INC_MSB 12
`define INC_LSB 0
`define SCALE_CTRL_MASK 32'h00181fff
`define SCALE_CTRL_RESET 32'h00000000

// mode register: set for rgb, clear for yuv
`define MODE_RGB_BIT 0
`define MODE_RESET 1'b0

// status register fields
`define STAT_LEVEL_MSB 3
`define STAT_FULL_BIT 4
`define STAT_HLUMA_BIT 8
`define STAT_HCHROMA_BIT 9
`define STAT_VLUMA_BIT 10
`define STAT_VCHROMA_BIT 11

// phase units: one source sample is 4096
`define PHASE_ONE 13'h1000
`define FRAC_BITS 12

// pixel stream
`define PIX_WIDTH 24
`define FIFO_DEPTH 8
`define FIFO_AW 3

`endif

//--- sim/scaler_monitor.sv
// checker on the scaler filter control ports
// assumes it is bound onto the top module, one clock domain
`timescale 1ns/1ns
`include "video_scaler_regs.vh"
`default_nettype none
module scaler_monitor (
  // watched ports
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_vsync,
  input wire logic i_vline_done,
  input wire logic o_out_valid,
  input wire logic [23:0] o_out_data,
  input wire logic i_out_ready,
  input wire logic [11:0] o_vphase,
  input wire logic o_vline_advance,
  input wire logic o_vert_luma_on
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence stall_s;
    o_out_valid && !i_out_ready;
  endsequence
  sequence held_s;
    o_out_valid && $stable(o_out_data);
  endsequence
  a_rsv_read_zero: assert property ($past(i_rd) && ($past(i_addr) == 8'h20 ||
    $past(i_addr) == 8'h28) |-> (o_rdata & ~`SCALE_CTRL_MASK) == 32'h0)
    else $error("reserved bits read nonzero");
  a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) == 8'h24
    |-> o_rdata == 32'h0) else $error("unmapped read nonzero");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data without read");
  a_vsync_clears: assert property ($past(i_vsync) |-> o_vphase == 12'h0 &&
    !o_vline_advance) else $error("vsync did not clear phase");
  a_vadv_cause: assert property (o_vline_advance |-> $past(i_vline_done))
    else $error("line advance without line done");
  a_vphase_hold: assert property (!$past(i_vline_done) && !$past(i_vsync)
    |-> $stable(o_vphase)) else $error("phase moved without cause");
  a_venable_sync: assert property ($changed(o_vert_luma_on) |-> $past(i_vsync, 2))
    else $error("enable changed outside vsync");
  a_out_hold: assert property (stall_s |=> held_s)
    else $error("output dropped while stalled");
endmodule // scaler_monitor

bind video_scaler_filter_control scaler_monitor mon (.i_clock, .i_rst_n, .i_addr, .i_rd,
  .o_rdata, .i_vsync, .i_vline_done, .o_out_valid, .o_out_data, .i_out_ready, .o_vphase,
  .o_vline_advance, .o_vert_luma_on);
`default_nettype wire

//--- sim/video_scaler_filter_control_bench.sv
// self-checking bench for the scaler filter control
// assumes the design's register port, vsync and pixel stream contract
`timescale 1ns/1ns
`default_nettype none
`define chk(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module video_scaler_filter_control_bench;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0, i_rd = 1'b0, i_vsync = 1'b0, i_hline_start = 1'b0;
  logic i_vline_done = 1'b0, i_pix_valid = 1'b0, i_out_ready = 1'b0;
  logic [23:0] i_pix_data = 24'h0;
  wire [31:0] o_rdata;
  wire [23:0] o_out_data;
  wire [11:0] o_vphase;
  wire o_pix_ready, o_out_valid, o_vline_advance, o_vert_luma_on, o_vert_chroma_on;
  int miscompares = 0, n_compared = 0, cycles = 0, f, hinc, idx, pushed;
  logic [31:0] d, ctrl;
  logic [7:0] a;
  logic [2:0] en;
  logic [23:0] pix [10];
  logic mode;
  video_scaler_filter_control dut (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_vsync, .i_hline_start, .i_vline_done, .i_pix_valid, .i_pix_data,
    .o_pix_ready, .o_out_valid, .o_out_data, .i_out_ready, .o_vphase, .o_vline_advance,
    .o_vert_luma_on, .o_vert_chroma_on);
  always #5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic rst();
    i_rst_n <= 1'b0;
    i_out_ready <= 1'b0;
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= dt;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 `chk(o_rdata, ex)
  endtask
  task automatic sync();
    @(posedge i_clock);
    i_vsync <= 1'b1;
    @(posedge i_clock);
    i_vsync <= 1'b0;
    @(posedge i_clock);
  endtask
  function automatic logic [23:0] mix(logic [23:0] p, logic [23:0] q, int w, logic [2:0] e);
    logic [23:0] r;
    for (int c = 0; c < 3; c++)
      r[c*8+:8] = e[c] ? 8'((p[c*8+:8] * (4096 - w) + q[c*8+:8] * w) >> 12) : p[c*8+:8];
    return r;
  endfunction
  initial begin
    void'($urandom(41));
    rst();
    rd(8'h20, 32'h0);
    rd(8'h28, 32'h0);
    rd(8'h24, 32'h0);
    for (int n = 0; n < 6; n++) begin
      d = (n == 0) ? 32'hffffffff : $urandom;
      a = n[0] ? 8'h28 : 8'h20;
      wr(a, d);
      rd(a, d & 32'h00181fff);
    end
    hinc = 1 + $urandom % 4096;
    wr(8'h20, 32'h00180000);
    wr(8'h28, 32'h00180000 | hinc);
    rd(8'h44, 32'h0);
    sync();
    rd(8'h44, 32'h00000f00);
    f = 0;
    for (int n = 0; n < 6; n++) begin
      @(posedge i_clock);
      i_vline_done <= 1'b1;
      @(posedge i_clock);
      i_vline_done <= 1'b0;
      f = f + hinc;
      #1 `chk(o_vline_advance, f >= 4096)
      f = f % 4096;
      `chk(o_vphase, 12'(f))
    end
    for (int k = 0; k < 5; k++) begin
      mode = (k == 3);
      // rgb case keeps both enable bits equal
      ctrl = (k == 0 || k == 3) ? 32'h00180000 : (k == 1) ? 32'h00100000 :
        (k == 2) ? 32'h00080000 : 32'h0;
      en = {{2{mode ? ctrl[20] : ctrl[19]}}, ctrl[20]};
      hinc = (k == 0) ? 4096 : 1 + $urandom % 4096;
      @(posedge i_clock);
      rst();
      wr(8'h40, {31'h0, mode});
      wr(8'h20, ctrl | hinc);
      wr(8'h28, ctrl);
      sync();
      i_hline_start <= 1'b1;
      @(posedge i_clock);
      i_hline_start <= 1'b0;
      foreach (pix[j]) pix[j] = 24'($urandom);
      pushed = 0;
      fork
        begin
          i_pix_valid <= 1'b1;
          for (int j = 0; j < 10; j++) begin
            i_pix_data <= pix[j];
            do @(negedge i_clock); while (o_pix_ready !== 1'b1);
            @(posedge i_clock);
            pushed++;
          end
          i_pix_valid <= 1'b0;
        end
        begin
          wait (pushed == 10);
          @(negedge i_clock);
          // a first step of a full sample pops a third pixel before the stall
          `chk(o_pix_ready, (hinc >= 4096))
          `chk(o_vert_luma_on, en[0])
          `chk(o_vert_chroma_on, en[1])
          f = 0;
          idx = 0;
          for (int n = 0; n < 8; n++) begin
            do begin
              @(posedge i_clock);
              i_out_ready <= 1'($urandom);
              @(negedge i_clock);
            end while (!(o_out_valid === 1'b1 && i_out_ready));
            `chk(o_out_data, mix(pix[idx], pix[idx+1], f, en))
            f = f + hinc;
            if (f >= 4096) begin
              f = f - 4096;
              idx++;
            end
          end
        end
      join
    end
    wrap_up();
  end
endmodule // video_scaler_filter_control_bench
`default_nettype wire
